// ==== src/dly_host_cfg.svh ====
// Constants for the delay-line step code programming controller.
`ifndef DLY_HOST_CFG_SVH
`define DLY_HOST_CFG_SVH

// Own register map, byte addresses on the AXI4-Lite port.
`define REG_CTRL 8'h00
`define REG_TX 8'h04
`define REG_CMD 8'h08
`define REG_STAT 8'h0C
`define REG_RX 8'h10

// Control register fields.
`define CTRL_PAR_BIT 0
`define CTRL_TRANSP_BIT 1
`define CTRL_RESTORE_BIT 2
`define CTRL_CHAIN_LSB 4
`define CTRL_CHAIN_MSB 5
`define CTRL_RESET 32'h0000_0000

// Command and status fields.
`define CMD_GO_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_FROZEN_BIT 1

// Bus responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Clock period in picoseconds.
`define CLK_PS 8000

// Pin timing figures in nanoseconds.
`define PARALLEL_SETTLE_TIME_NS 40
`define STROBE_SETTLE_TIME_NS 45
`define T_EW_NS 10
`define T_DSE_NS 10
`define T_ES_NS 10
`define T_EH_NS 10
`define STROBE_TO_SHIFT_OUT_VALID_NS 20
`define T_CQV_NS 20
`define MAX_DELAY_NS 2000

// Least time in ns rounded up to whole clock cycles, at least one.
`define CYC_UP(ns) ((((ns) * 1000 + `CLK_PS - 1) / `CLK_PS) < 1 ? 1 : \
    (((ns) * 1000 + `CLK_PS - 1) / `CLK_PS))

// Two-flop synchroniser depth on the returned serial data.
`define SYNC_CYC 2

`endif

// ==== src/dly_host_pkg.sv ====
// Types shared by the delay-line step code programming controller.
package dly_host_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [8:0] {
        ST_IDLE = 9'b0_0000_0001,
        ST_FREEZE = 9'b0_0000_0010,
        ST_PSETUP = 9'b0_0000_0100,
        ST_STROBE = 9'b0_0000_1000,
        ST_LEAD = 9'b0_0001_0000,
        ST_SC_LOW = 9'b0_0010_0000,
        ST_SC_HIGH = 9'b0_0100_0000,
        ST_TAIL = 9'b0_1000_0000,
        ST_SETTLE = 9'b1_0000_0000
    } seq_state_e;

    typedef logic [15:0] cnt_t;

endpackage : dly_host_pkg

// ==== src/dly_host.sv ====
// Host controller that programs the delay line's step code over its pins.
//
// Notes on behaviour
// - Freeze input for max delay before update.
// - Keep input frozen until settling time passes.
// - Step code pins held in own register.
// - Serial: shift on clock rise, MSB first.
// - Chain: eight bits per device, MSB first.
// - First rise returns bit 6; seven more edges.
// - Readback rewritten before strobe falls.
`timescale 1ns/100ps
`include "dly_host_cfg.svh"

module dly_host
    import dly_host_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int N_DEV = 4,
    parameter int MAX_DELAY_NS = `MAX_DELAY_NS
)
(
    input wire logic CLK, // System clock, 125 MHz.
    input wire logic RST_B, // Synchronous reset, active low.
    input wire logic AWVALID, // Write address valid.
    output logic AWREADY, // Write address ready.
    input wire logic [ADDR_W-1:0] AWADDR, // Write address.
    input wire logic WVALID, // Write data valid.
    output logic WREADY, // Write data ready.
    input wire logic [31:0] WDATA, // Write data.
    input wire logic [3:0] WSTRB, // Write byte strobes.
    output logic BVALID, // Write response valid.
    input wire logic BREADY, // Write response ready.
    output logic [1:0] BRESP, // Write response.
    input wire logic ARVALID, // Read address valid.
    output logic ARREADY, // Read address ready.
    input wire logic [ADDR_W-1:0] ARADDR, // Read address.
    output logic RVALID, // Read data valid.
    input wire logic RREADY, // Read data ready.
    output logic [31:0] RDATA, // Read data.
    output logic [1:0] RRESP, // Read response.
    input wire logic SIG_IN, // Signal to be delayed, same clock.
    output logic DLY_IN, // Signal driven to the delay line input.
    output logic INTERFACE_SELECT, // High parallel, low serial.
    output logic LOAD_STROBE, // Strobe to the delay line.
    output logic [7:0] STEP_CODE, // Parallel step code pins.
    output logic STEP_CODE_OE, // High while step code pins are driven.
    output logic SHIFT_CLK, // Serial shift clock, made here.
    output logic SHIFT_DATA, // Serial data into the chain.
    input wire logic SHIFT_RET // Serial data back from the chain.
);

    localparam int PDV_CYC = `CYC_UP(`PARALLEL_SETTLE_TIME_NS);
    localparam int EDV_CYC = `CYC_UP(`STROBE_SETTLE_TIME_NS);
    localparam int EW_CYC = `CYC_UP(`T_EW_NS);
    localparam int DSE_CYC = `CYC_UP(`T_DSE_NS);
    localparam int EH_CYC = `CYC_UP(`T_EH_NS);
    localparam int FRZ_CYC = `CYC_UP(MAX_DELAY_NS);
    // Wait for the returned bit to be valid and to clear the synchroniser.
    localparam int LEAD_CYC = `CYC_UP(`STROBE_TO_SHIFT_OUT_VALID_NS) + `SYNC_CYC;
    localparam int HALF_CYC = `CYC_UP(`T_CQV_NS);
    localparam int LEAD_MIN = `CYC_UP(`T_ES_NS);

    // Refuse settings the sequencer cannot serve.
    generate
        if (N_DEV < 1 || N_DEV > 4 || ADDR_W < 5 || FRZ_CYC > 65535 ||
            LEAD_CYC < LEAD_MIN)
        begin : g_bad_cfg
            $error("dly_host: unsupported parameter values");
        end
    endgenerate

    // Byte-lane merge used for every writable register.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Word address decode shared by both bus directions.
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        return a[ADDR_W-1:2] == (ADDR_W-2)'(off[7:2]);
    endfunction : hit

    seq_state_e st_q;
    cnt_t cnt_q;
    logic [31:0] ctrl_q;
    logic [31:0] tx_q;
    logic [31:0] rx_q;
    logic [31:0] rd_q;
    logic [31:0] sh_q;
    logic [6:0] bits_q;
    logic [6:0] pass_bits_q;
    logic pass2_q;
    logic par_q;
    logic transp_q;
    logic restore_q;
    logic [5:0] align_q;
    logic go;
    logic wr_go;
    logic rd_go;
    logic cnt_done;
    logic ret_s1_q;
    logic ret_s2_q;
    logic [31:0] rdata_d;
    logic rd_ok;
    logic wr_ok;
    logic [2:0] chain_n;
    logic [31:0] back_w;

    assign cnt_done = cnt_q == 16'h0000;
    // Readback realigned so the farthest device's byte leads again.
    assign back_w = rx_q << align_q;
    assign chain_n = {1'b0, ctrl_q[`CTRL_CHAIN_MSB:`CTRL_CHAIN_LSB]} + 3'h1;

    // Write channel: both halves taken together, answered next cycle.
    assign wr_go = AWVALID && WVALID && !BVALID;
    assign AWREADY = wr_go;
    assign WREADY = wr_go;
    assign ARREADY = !RVALID;
    assign rd_go = ARVALID && !RVALID;
    assign wr_ok = hit(AWADDR, `REG_CTRL) || hit(AWADDR, `REG_TX) ||
        hit(AWADDR, `REG_CMD);
    // Start is ignored while busy; software polls the busy bit.
    assign go = wr_go && hit(AWADDR, `REG_CMD) && WSTRB[0] &&
        WDATA[`CMD_GO_BIT] && (st_q == ST_IDLE);

    // Writable registers.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            ctrl_q <= `CTRL_RESET;
            tx_q <= 32'h0000_0000;
        end
        else if (wr_go)
        begin
            if (hit(AWADDR, `REG_CTRL))
            begin
                ctrl_q <= merge(ctrl_q, WDATA, WSTRB);
            end
            if (hit(AWADDR, `REG_TX))
            begin
                tx_q <= merge(tx_q, WDATA, WSTRB);
            end
        end
    end

    // Write response; an unmapped address gets a slave error.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end
        else if (wr_go)
        begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (BREADY)
        begin
            BVALID <= 1'b0;
        end
    end

    // Read data mux.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        rd_ok = 1'b1;
        if (hit(ARADDR, `REG_CTRL))
        begin
            rdata_d = ctrl_q;
        end
        else if (hit(ARADDR, `REG_TX))
        begin
            rdata_d = tx_q;
        end
        else if (hit(ARADDR, `REG_CMD))
        begin
            rdata_d = 32'h0000_0000;
        end
        else if (hit(ARADDR, `REG_STAT))
        begin
            rdata_d[`STAT_BUSY_BIT] = st_q != ST_IDLE;
            rdata_d[`STAT_FROZEN_BIT] = st_q != ST_IDLE;
            rdata_d[15:8] = STEP_CODE;
        end
        else if (hit(ARADDR, `REG_RX))
        begin
            rdata_d = rd_q;
        end
        else
        begin
            rd_ok = 1'b0;
        end
    end

    // Read response, registered.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= `RESP_OKAY;
        end
        else if (rd_go)
        begin
            RVALID <= 1'b1;
            RDATA <= rdata_d;
            RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (RREADY)
        begin
            RVALID <= 1'b0;
        end
    end

    // Returned serial data crosses in through two flops before any use.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            ret_s1_q <= 1'b0;
            ret_s2_q <= 1'b0;
        end
        else
        begin
            ret_s1_q <= SHIFT_RET;
            ret_s2_q <= ret_s1_q;
        end
    end

    // The delayed signal is held idle for the whole update so no spurious
    // edges leave the line; the cost is a lost stretch of input.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            DLY_IN <= 1'b0;
        end
        else if (st_q == ST_IDLE && !go)
        begin
            DLY_IN <= SIG_IN;
        end
    end

    // Sequencer: state, timer and pin drive.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            par_q <= 1'b0;
            transp_q <= 1'b0;
            restore_q <= 1'b0;
            align_q <= 6'h00;
            INTERFACE_SELECT <= 1'b0;
            LOAD_STROBE <= 1'b0;
            STEP_CODE <= 8'h00;
            STEP_CODE_OE <= 1'b0;
            SHIFT_CLK <= 1'b0;
            SHIFT_DATA <= 1'b0;
        end
        else
        begin
            if (!cnt_done)
            begin
                cnt_q <= cnt_q - 16'h0001;
            end
            unique case (st_q)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        par_q <= ctrl_q[`CTRL_PAR_BIT];
                        transp_q <= ctrl_q[`CTRL_TRANSP_BIT];
                        restore_q <= ctrl_q[`CTRL_RESTORE_BIT];
                        align_q <= 6'(8 * (4 - int'(chain_n)));
                        cnt_q <= 16'(FRZ_CYC);
                        st_q <= ST_FREEZE;
                    end
                end
                ST_FREEZE:
                begin
                    if (cnt_done && par_q)
                    begin
                        INTERFACE_SELECT <= 1'b1;
                        STEP_CODE_OE <= 1'b1;
                        STEP_CODE <= tx_q[7:0];
                        if (transp_q)
                        begin
                            LOAD_STROBE <= 1'b1;
                            cnt_q <= 16'(PDV_CYC);
                            st_q <= ST_SETTLE;
                        end
                        else
                        begin
                            LOAD_STROBE <= 1'b0;
                            cnt_q <= 16'(DSE_CYC);
                            st_q <= ST_PSETUP;
                        end
                    end
                    else if (cnt_done)
                    begin
                        // One code pin must float in serial mode.
                        INTERFACE_SELECT <= 1'b0;
                        STEP_CODE_OE <= 1'b0;
                        SHIFT_CLK <= 1'b0;
                        LOAD_STROBE <= 1'b1;
                        cnt_q <= 16'(LEAD_CYC);
                        st_q <= ST_LEAD;
                    end
                end
                ST_PSETUP:
                begin
                    if (cnt_done)
                    begin
                        LOAD_STROBE <= 1'b1;
                        cnt_q <= 16'(EW_CYC);
                        st_q <= ST_STROBE;
                    end
                end
                ST_STROBE:
                begin
                    if (cnt_done)
                    begin
                        LOAD_STROBE <= 1'b0;
                        cnt_q <= 16'(EDV_CYC);
                        st_q <= ST_SETTLE;
                    end
                end
                ST_LEAD:
                begin
                    if (cnt_done)
                    begin
                        SHIFT_DATA <= sh_q[31];
                        cnt_q <= 16'(HALF_CYC);
                        st_q <= ST_SC_LOW;
                    end
                end
                ST_SC_LOW:
                begin
                    if (cnt_done)
                    begin
                        SHIFT_CLK <= 1'b1;
                        cnt_q <= 16'(HALF_CYC);
                        st_q <= ST_SC_HIGH;
                    end
                end
                ST_SC_HIGH:
                begin
                    if (cnt_done)
                    begin
                        SHIFT_CLK <= 1'b0;
                        if (bits_q != 7'h00)
                        begin
                            SHIFT_DATA <= sh_q[31];
                            cnt_q <= 16'(HALF_CYC);
                            st_q <= ST_SC_LOW;
                        end
                        else if (restore_q && !pass2_q)
                        begin
                            // The restore pass starts at once; its first bit
                            // comes from the readback, as sh_q loads now.
                            SHIFT_DATA <= back_w[31];
                            cnt_q <= 16'(HALF_CYC);
                            st_q <= ST_SC_LOW;
                        end
                        else
                        begin
                            cnt_q <= 16'(EH_CYC);
                            st_q <= ST_TAIL;
                        end
                    end
                end
                ST_TAIL:
                begin
                    // Strobe falls only after every bit, so no clock edge
                    // ever reaches the line while the strobe is low.
                    if (cnt_done)
                    begin
                        LOAD_STROBE <= 1'b0;
                        cnt_q <= 16'(EDV_CYC);
                        st_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    if (cnt_done)
                    begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift data path: outgoing word, bit counter and returned word.
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            sh_q <= 32'h0000_0000;
            rx_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            bits_q <= 7'h00;
            pass_bits_q <= 7'h00;
            pass2_q <= 1'b0;
        end
        else if (st_q == ST_FREEZE && cnt_done && !par_q)
        begin
            // Farthest device's byte leads, each byte MSB first.
            sh_q <= tx_q << align_q;
            bits_q <= 7'(32 - int'(align_q));
            pass_bits_q <= 7'(32 - int'(align_q));
            pass2_q <= 1'b0;
            rx_q <= 32'h0000_0000;
        end
        else if (st_q == ST_SC_LOW && cnt_done)
        begin
            // Sample just before the rise: the bit the chain now presents.
            rx_q <= {rx_q[30:0], ret_s2_q};
            sh_q <= {sh_q[30:0], 1'b0};
            bits_q <= bits_q - 7'h01;
        end
        else if (st_q == ST_SC_HIGH && cnt_done && bits_q == 7'h00 &&
                 !pass2_q)
        begin
            rd_q <= rx_q;
            if (restore_q)
            begin
                // Readback wiped the chain; shift the old codes back in.
                sh_q <= back_w;
                bits_q <= pass_bits_q;
                pass2_q <= 1'b1;
            end
        end
    end

    // A restore pass continues the clock train instead of ending it.
    // The chain output is not sampled once the strobe is low.

endmodule : dly_host

// ==== test/dly_host_monitor.sv ====
// Port checker for the delay-line step code programming controller.
`timescale 1ns/100ps

module dly_host_monitor
#(
    parameter int MAX_DELAY_NS = 2000
)
(
    input wire logic CLK, // System clock.
    input wire logic RST_B, // Synchronous reset, active low.
    input wire logic AWVALID, // Write address valid.
    input wire logic WVALID, // Write data valid.
    input wire logic BVALID, // Write response valid.
    input wire logic BREADY, // Write response ready.
    input wire logic [1:0] BRESP, // Write response.
    input wire logic ARVALID, // Read address valid.
    input wire logic RVALID, // Read data valid.
    input wire logic DLY_IN, // Delay line input.
    input wire logic INTERFACE_SELECT, // Parallel or serial.
    input wire logic LOAD_STROBE, // Device strobe.
    input wire logic [7:0] STEP_CODE, // Parallel code pins.
    input wire logic SHIFT_CLK, // Serial clock.
    input wire logic SHIFT_DATA // Serial data out.
);
    localparam int FRZ = (MAX_DELAY_NS * 1000 + 7999) / 8000;
    logic [15:0] still_q;
    logic [15:0] bits_q;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // Counts cycles that the delay line input has stayed put.
    always_ff @(posedge CLK)
    begin
        if (!RST_B || DLY_IN != $past(DLY_IN))
            still_q <= 16'h0000;
        else if (still_q != 16'hFFFF)
            still_q <= still_q + 16'h0001;
    end

    // Counts shift clock rises within one strobe frame.
    always_ff @(posedge CLK)
    begin
        if (!RST_B || $rose(LOAD_STROBE))
            bits_q <= 16'h0000;
        else if ($rose(SHIFT_CLK))
            bits_q <= bits_q + 16'h0001;
    end

    freeze_before_a: assert property (($changed(STEP_CODE) ||
        $fell(LOAD_STROBE)) |-> still_q >= FRZ - 1)
        else $error("Code moved while input was not idle long enough.");
    settle_latch_a: assert property ($fell(LOAD_STROBE) |=>
        $stable(DLY_IN)[*6]) else $error("Input moved during settling.");
    settle_transp_a: assert property (INTERFACE_SELECT && LOAD_STROBE &&
        $changed(STEP_CODE) |=> $stable(DLY_IN)[*5])
        else $error("Input moved during parallel settling.");
    shift_frame_a: assert property ($rose(SHIFT_CLK) |->
        LOAD_STROBE && !INTERFACE_SELECT)
        else $error("Shift clock outside a serial frame.");
    data_setup_a: assert property ($rose(SHIFT_CLK) |-> $stable(SHIFT_DATA)
        && $past(SHIFT_DATA, 2) == SHIFT_DATA)
        else $error("Serial data not set up before clock.");
    data_hold_a: assert property ($rose(SHIFT_CLK) |=>
        $stable(SHIFT_DATA)) else $error("Serial data not held.");
    bit_count_a: assert property ($fell(LOAD_STROBE) && !INTERFACE_SELECT
        |-> bits_q[2:0] == 3'b000 && bits_q != 16'h0000)
        else $error("Frame is not whole bytes.");
    clock_still_a: assert property (!LOAD_STROBE |-> !SHIFT_CLK)
        else $error("Shift clock high with strobe low.");
    strobe_width_a: assert property ($rose(LOAD_STROBE) |=> LOAD_STROBE)
        else $error("Strobe pulse too short.");
    write_answer_a: assert property (AWVALID && WVALID && !BVALID |=> BVALID)
        else $error("Write response late.");
    read_answer_a: assert property (ARVALID && !RVALID |=> RVALID)
        else $error("Read response late.");
    resp_hold_a: assert property (BVALID && !BREADY |=> BVALID &&
        $stable(BRESP)) else $error("Write response dropped.");

    cover property ($fell(LOAD_STROBE) && !INTERFACE_SELECT);
    cover property (INTERFACE_SELECT && LOAD_STROBE && $changed(STEP_CODE));
    cover property (BVALID && BRESP == 2'b10);
endmodule : dly_host_monitor

bind dly_host dly_host_monitor #(.MAX_DELAY_NS(MAX_DELAY_NS)) u_mon (
    .CLK(CLK), .RST_B(RST_B), .AWVALID(AWVALID), .WVALID(WVALID),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .RVALID(RVALID), .DLY_IN(DLY_IN), .INTERFACE_SELECT(INTERFACE_SELECT),
    .LOAD_STROBE(LOAD_STROBE), .STEP_CODE(STEP_CODE),
    .SHIFT_CLK(SHIFT_CLK), .SHIFT_DATA(SHIFT_DATA));

// ==== test/dly_chain_model.sv ====
// Behavioural model of a chain of programmable delay-line devices.
`timescale 1ns/100ps

module dly_chain_model
#(
    parameter int N = 2
)
(
    input wire logic interface_select_pin, // High parallel, low serial.
    input wire logic load_strobe_pin, // Load strobe.
    input wire logic [7:0] step_code_pins, // Parallel code pins.
    input wire logic shift_clock_pin, // Serial clock from the host.
    input wire logic shift_in, // Serial data into device 0.
    output logic shift_out, // Serial data from the last device.
    output logic [8*N-1:0] dev_code // Active code, device k in byte k.
);
    // The part has no reset, so power-up contents are simply zero here.
    logic [8*N-1:0] sreg_q = '0;
    logic [8*N-1:0] active_q = '0;

    // Chain shifts as one long register; old bits leave at the top.
    always @(posedge shift_clock_pin)
    begin
        if (load_strobe_pin && !interface_select_pin)
            sreg_q <= {sreg_q[8*N-2:0], shift_in};
    end

    // Strobe fall loads the pins or the shifted bits.
    always @(negedge load_strobe_pin)
    begin
        if (interface_select_pin)
            active_q[7:0] <= step_code_pins;
        else
            active_q <= sreg_q;
    end

    // Transparent mode follows the pins; top pin is the MSB.
    assign dev_code[7:0] = (interface_select_pin && load_strobe_pin) ?
        step_code_pins : active_q[7:0];
    assign dev_code[8*N-1:8] = active_q[8*N-1:8];
    // Released line shows the inverse so a stale value never passes.
    assign shift_out = (load_strobe_pin && !interface_select_pin) ?
        sreg_q[8*N-1] : ~sreg_q[8*N-1];
endmodule : dly_chain_model

// ==== test/dly_host_test.sv ====
// Self-checking bench for the delay-line programming controller.
`timescale 1ns/100ps
`include "dly_host_cfg.svh"

module dly_host_test;
    import dly_host_pkg::*;
    logic CLK = 0, RST_B = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
    logic ARVALID = 0, RREADY = 0, SIG_IN = 0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [3:0] WSTRB = 4'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DLY_IN, SHIFT_DATA;
    logic INTERFACE_SELECT, LOAD_STROBE, STEP_CODE_OE, SHIFT_CLK, SHIFT_RET;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic [7:0] STEP_CODE;
    wire [7:0] step_pins = STEP_CODE_OE ? STEP_CODE : ~STEP_CODE;
    wire [15:0] dev_code;
    int bad_count = 0, checks = 0, cyc = 0;

    dly_host #(.MAX_DELAY_NS(40)) dut (.CLK(CLK), .RST_B(RST_B),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
        .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
        .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
        .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
        .SIG_IN(SIG_IN), .DLY_IN(DLY_IN),
        .INTERFACE_SELECT(INTERFACE_SELECT), .LOAD_STROBE(LOAD_STROBE),
        .STEP_CODE(STEP_CODE), .STEP_CODE_OE(STEP_CODE_OE),
        .SHIFT_CLK(SHIFT_CLK), .SHIFT_DATA(SHIFT_DATA),
        .SHIFT_RET(SHIFT_RET));
    dly_chain_model #(.N(2)) u_chain (.interface_select_pin(INTERFACE_SELECT),
        .load_strobe_pin(LOAD_STROBE), .step_code_pins(step_pins),
        .shift_clock_pin(SHIFT_CLK), .shift_in(SHIFT_DATA),
        .shift_out(SHIFT_RET), .dev_code(dev_code));

    // Clock, a toggling input so freezes show, and the hang limit.
    always #4 CLK = ~CLK;
    always @(posedge CLK) SIG_IN <= ~SIG_IN;
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Address and data go out together; both are taken on one edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        @(posedge CLK);
        AWVALID <= 1'b1; AWADDR <= a; WVALID <= 1'b1; WDATA <= d;
        WSTRB <= s;
        do @(posedge CLK); while (AWREADY !== 1'b1);
        AWVALID <= 1'b0; WVALID <= 1'b0;
        // One cycle with the answer held back exercises the response hold.
        @(posedge CLK);
        BREADY <= 1'b1;
        do @(posedge CLK); while (BVALID !== 1'b1);
        r = BRESP;
        BREADY <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge CLK);
        ARVALID <= 1'b1; ARADDR <= a; RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        while (RVALID !== 1'b1) @(posedge CLK);
        d = RDATA; r = RRESP;
        RREADY <= 1'b0;
    endtask : rd

    // Loads control and payload, starts, and polls until not busy.
    task automatic run(input logic [31:0] ctl, input logic [31:0] tx,
                       output logic [31:0] st);
        logic [1:0] r;
        int n;
        wr(`REG_CTRL, ctl, 4'hF, r);
        wr(`REG_TX, tx, 4'hF, r);
        wr(`REG_CMD, 32'h0000_0001, 4'hF, r);
        n = 0;
        do
        begin
            rd(`REG_STAT, st, r);
            n++;
        end
        while (st[0] !== 1'b0 && n < 400);
        if (st[0] !== 1'b0)
        begin
            bad_count++;
            end_of_test();
        end
    endtask : run

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        rd(`REG_CTRL, d, r);
        chk(d, `CTRL_RESET);
        @(negedge CLK);
        chk({31'h0, DLY_IN}, {31'h0, ~SIG_IN});
        rd(`REG_STAT, d, r);
        chk(d, 32'h0000_0000);
        rd(8'h14, d, r);
        chk({d[31:2], r}, {30'h0, `RESP_SLVERR});
        wr(8'h14, 32'hFFFF_FFFF, 4'hF, r);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    endtask : t_regs

    task automatic t_parallel;
        logic [31:0] st;
        run(32'h0000_0003, 32'h0000_00A5, st);
        chk({16'h0, st[15:8], dev_code[7:0]}, 32'h0000_A5A5);
        run(32'h0000_0003, 32'h0000_005A, st);
        chk({24'h0, dev_code[7:0]}, 32'h0000_005A);
        run(32'h0000_0001, 32'h0000_003C, st);
        chk({23'h0, LOAD_STROBE, dev_code[7:0]}, 32'h0000_003C);
    endtask : t_parallel

    task automatic t_serial;
        logic [31:0] st;
        logic [31:0] d;
        logic [1:0] r;
        run(32'h0000_0010, 32'h0000_1234, st);
        chk({16'h0, dev_code}, 32'h0000_1234);
        run(32'h0000_0010, 32'h0000_5678, st);
        rd(`REG_RX, d, r);
        chk({d[15:0], dev_code}, 32'h1234_5678);
        run(32'h0000_0014, 32'h0000_9999, st);
        rd(`REG_RX, d, r);
        chk({d[15:0], dev_code}, 32'h5678_5678);
        wr(`REG_CTRL, 32'h0000_0000, 4'h2, r);
        rd(`REG_CTRL, d, r);
        chk(d, 32'h0000_0014);
    endtask : t_serial

    task end_of_test;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // Reset, then each scenario in turn.
    initial
    begin
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        t_regs();
        t_parallel();
        t_serial();
        end_of_test();
    end
endmodule : dly_host_test
